// >>> pkg/rx_port_map.vh
// register offsets, field positions and reset values of the receive output port
`ifndef RX_PORT_MAP_VH
`define RX_PORT_MAP_VH

// ------------------------------------------------------------
// apb register offsets
// ------------------------------------------------------------
`define ADDR_W          8
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_COUNT      8'h08
`define ADDR_PINS       8'h0c
`define ADDR_UNDER      8'h10

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define CTRL_W          4
`define CTRL_WIDTH8     0
`define CTRL_DEC_EN     1
`define CTRL_FIFO_EN    2
`define CTRL_OUT_DIS    3
`define CTRL_RESET      4'h7

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define STAT_SELECTED   0
`define STAT_EN_ACTIVE  1
`define STAT_FLAG       2
`define STAT_POL_HIGH   3
`define STAT_CE_LOW     4

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define CHAR_W          12
`define CNT_W           16

`endif

// >>> hw/pin_sync.v
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter W    = 1,
  parameter INIT = 1'b0
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         clk_en,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] pin_sync_q
);

  reg [W-1:0] stage1_q;
  reg [W-1:0] stage2_q;

  // stage1 feeds stage2 only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_q <= {W{INIT}};
      stage2_q <= {W{INIT}};
    end else if (clk_en) begin
      stage1_q <= pin_in;
      stage2_q <= stage1_q;
    end
  end

  assign pin_sync_q = stage2_q;

endmodule

// >>> hw/select_tracker.v
// output enable polarity, chip select sequence and selection state
`timescale 1ns/1ns
module select_tracker (
  input  wire pclk,
  input  wire presetn,
  input  wire clk_en,
  input  wire enable_s,
  input  wire chip_select_n_s,
  input  wire polarity_high_s,
  output wire enable_active,
  output wire read_strobe,
  output wire ce_low,
  output wire selected
);

  reg ce_low_q;
  reg selected_q;
  reg selected_d;

  // ------------------------------------------------------------
  // polarity and qualification
  // ------------------------------------------------------------
  assign enable_active = polarity_high_s ? enable_s : ~enable_s;

  // a read happens on an active edge when selected or becoming selected
  assign read_strobe = enable_active & (selected_q | ce_low_q);

  always @* begin
    selected_d = selected_q;
    if (enable_active && ce_low_q) begin
      selected_d = 1'b1;
    end else if (!enable_active) begin
      selected_d = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_low_q   <= 1'b0;
      selected_q <= 1'b0;
    end else if (clk_en) begin
      ce_low_q   <= ~chip_select_n_s;
      selected_q <= selected_d;
    end
  end

  assign ce_low   = ce_low_q;
  assign selected = selected_q;

endmodule

// >>> hw/rx_parallel_output_port.v
// receive-side parallel output port with apb control and status
`timescale 1ns/1ns
`include "rx_port_map.vh"
module rx_parallel_output_port #(
  parameter CNT_W = `CNT_W
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 clk_en,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [`ADDR_W-1:0]   paddr,
  input  wire [31:0]          pwdata,
  output wire [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  input  wire                 receive_output_enable,
  input  wire                 chip_select_n,
  input  wire                 cascade_fifo_select,
  input  wire                 char_valid,
  output wire                 char_ready,
  input  wire                 char_is_cmd,
  input  wire [`CHAR_W-1:0]   char_bits,
  output wire [9:0]           receive_data_bus,
  output wire                 receive_data_bus_oe,
  output wire [1:0]           receive_command_bus,
  output wire                 receive_command_bus_oe,
  output wire                 command_data_flag,
  output wire                 command_data_flag_oe
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [2:0] pins_s;

  // the enable pin idles inactive for active-low hosts: pulled up
  pin_sync #(
    .W    (3),
    .INIT (1'b1)
  ) u_pin_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .pin_in     ({cascade_fifo_select, chip_select_n, receive_output_enable}),
    .pin_sync_q (pins_s)
  );

  // ------------------------------------------------------------
  // selection
  // ------------------------------------------------------------
  wire enable_active;
  wire read_strobe;
  wire ce_low;
  wire selected;

  select_tracker u_select (
    .pclk            (pclk),
    .presetn         (presetn),
    .clk_en          (clk_en),
    .enable_s        (pins_s[0]),
    .chip_select_n_s (pins_s[1]),
    .polarity_high_s (pins_s[2]),
    .enable_active   (enable_active),
    .read_strobe     (read_strobe),
    .ce_low          (ce_low),
    .selected        (selected)
  );

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  reg  [`CTRL_W-1:0] ctrl_q;
  wire               width8;
  wire               dec_en;
  wire               fifo_en;
  wire               out_dis;

  assign width8  = ctrl_q[`CTRL_WIDTH8];
  assign dec_en  = ctrl_q[`CTRL_DEC_EN];
  assign fifo_en = ctrl_q[`CTRL_FIFO_EN];
  assign out_dis = ctrl_q[`CTRL_OUT_DIS];

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire apb_access;
  wire apb_write;
  wire apb_setup;
  reg  addr_hit;
  reg  rd_valid_q;

  always @* begin
    case (paddr)
      `ADDR_CTRL:   addr_hit = 1'b1;
      `ADDR_STATUS: addr_hit = 1'b1;
      `ADDR_COUNT:  addr_hit = 1'b1;
      `ADDR_PINS:   addr_hit = 1'b1;
      `ADDR_UNDER:  addr_hit = 1'b1;
      default:      addr_hit = 1'b0;
    endcase
  end

  // read data must be captured at an enabled edge before pready rises,
  // so a setup phase frozen by clk_en costs one wait state, not stale data
  assign pready     = clk_en & rd_valid_q;
  assign apb_setup  = psel & ~(penable & rd_valid_q);
  assign apb_access = psel & penable & pready;
  assign apb_write  = apb_access & pwrite & addr_hit;
  assign pslverr    = psel & penable & ~addr_hit;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_valid_q <= 1'b0;
    end else if (clk_en) begin
      rd_valid_q <= apb_setup;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (apb_write && paddr == `ADDR_CTRL) begin
      ctrl_q <= pwdata[`CTRL_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // character hand-off
  // ------------------------------------------------------------
  // with the fifo bypassed characters are pushed as they arrive;
  // with it enabled the host pulls one per clock while the enable is active and the port is selected or chip select is low
  wire take;
  wire underrun;

  assign char_ready = clk_en & (fifo_en ? read_strobe : 1'b1);
  assign take       = char_valid & char_ready;
  assign underrun   = clk_en & fifo_en & read_strobe & ~char_valid;

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  reg [9:0] data_pin_q;
  reg [9:0] data_pin_d;
  reg [1:0] cmd_pin_q;
  reg [1:0] cmd_pin_d;
  reg       flag_q;
  reg       flag_d;
  reg       oe_q;

  always @* begin
    data_pin_d = data_pin_q;
    cmd_pin_d  = cmd_pin_q;
    flag_d     = flag_q;
    if (take) begin
      if (!dec_en) begin
        // raw characters; upper two bits exist only for 12-bit ones
        data_pin_d = char_bits[9:0];
        cmd_pin_d  = width8 ? 2'b00 : char_bits[11:10];
        flag_d     = 1'b0;
      end else if (width8) begin
        if (char_is_cmd) begin
          data_pin_d[9:8] = char_bits[3:2];
          cmd_pin_d       = char_bits[1:0];
          flag_d          = 1'b1;
        end else begin
          data_pin_d[7:0] = char_bits[7:0];
          flag_d          = 1'b0;
        end
      end else begin
        if (char_is_cmd) begin
          cmd_pin_d = char_bits[1:0];
          flag_d    = 1'b1;
        end else begin
          data_pin_d = char_bits[9:0];
          flag_d     = 1'b0;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_pin_q <= 10'h000;
      cmd_pin_q  <= 2'h0;
      flag_q     <= 1'b0;
      oe_q       <= 1'b0;
    end else if (clk_en) begin
      data_pin_q <= data_pin_d;
      cmd_pin_q  <= cmd_pin_d;
      flag_q     <= flag_d;
      // read_strobe is the next selection state: the pins drive from the
      // selecting edge, so the first character is not presented floating
      oe_q       <= read_strobe & ~out_dis;
    end
  end

  assign receive_data_bus       = data_pin_q;
  assign receive_command_bus    = cmd_pin_q;
  assign command_data_flag      = flag_q;
  assign receive_data_bus_oe    = oe_q;
  assign receive_command_bus_oe = oe_q;
  assign command_data_flag_oe   = oe_q;

  // ------------------------------------------------------------
  // delivery and underrun counters
  // ------------------------------------------------------------
  // an event in the clearing cycle counts as one, so none is lost
  reg  [CNT_W-1:0] data_cnt_q;
  reg  [CNT_W-1:0] cmd_cnt_q;
  reg  [CNT_W-1:0] under_cnt_q;
  wire             clr_count;
  wire             clr_under;
  wire             take_cmd;
  wire             take_data;

  assign clr_count = apb_write & (paddr == `ADDR_COUNT);
  assign clr_under = apb_write & (paddr == `ADDR_UNDER);
  assign take_cmd  = take & dec_en & char_is_cmd;
  assign take_data = take & ~(dec_en & char_is_cmd);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_cnt_q  <= {CNT_W{1'b0}};
      cmd_cnt_q   <= {CNT_W{1'b0}};
      under_cnt_q <= {CNT_W{1'b0}};
    end else if (clk_en) begin
      if (clr_count) begin
        data_cnt_q <= {{(CNT_W-1){1'b0}}, take_data};
        cmd_cnt_q  <= {{(CNT_W-1){1'b0}}, take_cmd};
      end else begin
        if (take_data && ~&data_cnt_q) begin
          data_cnt_q <= data_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (take_cmd && ~&cmd_cnt_q) begin
          cmd_cnt_q <= cmd_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      if (clr_under) begin
        under_cnt_q <= {{(CNT_W-1){1'b0}}, underrun};
      end else if (underrun && ~&under_cnt_q) begin
        under_cnt_q <= under_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // sampled in the setup phase so prdata comes from a flip-flop
  reg [31:0] rdata_d;
  reg [31:0] prdata_q;
  wire [15:0] data_cnt16;
  wire [15:0] cmd_cnt16;
  wire [15:0] under_cnt16;

  generate
    if (CNT_W >= 16) begin : g_cnt_trim
      assign data_cnt16  = data_cnt_q[15:0];
      assign cmd_cnt16   = cmd_cnt_q[15:0];
      assign under_cnt16 = under_cnt_q[15:0];
    end else begin : g_cnt_pad
      assign data_cnt16  = {{(16-CNT_W){1'b0}}, data_cnt_q};
      assign cmd_cnt16   = {{(16-CNT_W){1'b0}}, cmd_cnt_q};
      assign under_cnt16 = {{(16-CNT_W){1'b0}}, under_cnt_q};
    end
  endgenerate

  always @* begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `ADDR_CTRL: begin
        rdata_d[`CTRL_W-1:0] = ctrl_q;
      end
      `ADDR_STATUS: begin
        rdata_d[`STAT_SELECTED]  = selected;
        rdata_d[`STAT_EN_ACTIVE] = enable_active;
        rdata_d[`STAT_FLAG]      = flag_q;
        rdata_d[`STAT_POL_HIGH]  = pins_s[2];
        rdata_d[`STAT_CE_LOW]    = ce_low;
      end
      `ADDR_COUNT: begin
        rdata_d = {cmd_cnt16, data_cnt16};
      end
      `ADDR_PINS: begin
        rdata_d[9:0]   = data_pin_q;
        rdata_d[11:10] = cmd_pin_q;
        rdata_d[12]    = flag_q;
        rdata_d[13]    = oe_q;
      end
      `ADDR_UNDER: begin
        rdata_d[15:0] = under_cnt16;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (clk_en && apb_setup) begin
      prdata_q <= rdata_d;
    end
  end

  assign prdata = prdata_q;

endmodule

// >>> test/rx_port_chk.sv
// concurrent checks on the receive output port pins
`timescale 1ns/1ns
`include "rx_port_map.vh"
module rx_port_chk (
  input wire                pclk,
  input wire                presetn,
  input wire                clk_en,
  input wire                psel,
  input wire                penable,
  input wire                pwrite,
  input wire [`ADDR_W-1:0]  paddr,
  input wire [31:0]         pwdata,
  input wire                pready,
  input wire                receive_output_enable,
  input wire                chip_select_n,
  input wire                cascade_fifo_select,
  input wire                char_valid,
  input wire                char_ready,
  input wire                char_is_cmd,
  input wire [`CHAR_W-1:0]  char_bits,
  input wire [9:0]          receive_data_bus,
  input wire                receive_data_bus_oe,
  input wire [1:0]          receive_command_bus,
  input wire                receive_command_bus_oe,
  input wire                command_data_flag,
  input wire                command_data_flag_oe
);
  logic [3:0]  ctrl_q;
  logic [11:0] bits_q;
  wire         take = char_valid && char_ready;
  wire         w8   = ctrl_q[`CTRL_WIDTH8];
  wire         dec  = ctrl_q[`CTRL_DEC_EN];
  wire         fifo = ctrl_q[`CTRL_FIFO_EN];
  wire [12:0]  outs = {receive_data_bus, receive_command_bus, command_data_flag};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // control mirror, not visible at the pins
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (psel && penable && pready && pwrite && paddr == `ADDR_CTRL) begin
      ctrl_q <= pwdata[3:0];
    end
  end
  always_ff @(posedge pclk) begin
    bits_q <= char_bits;
  end
  sequence s_en_off;
    (receive_output_enable != cascade_fifo_select) && clk_en;
  endsequence
  sequence s_first_take;
    fifo && $rose(char_ready);
  endsequence
  AST_OE_TIED:
    assert property (receive_data_bus_oe == command_data_flag_oe &&
      receive_command_bus_oe == command_data_flag_oe) else $error("oe lines differ");
  AST_SEL_AFTER_CE:
    assert property (s_first_take |-> $past(chip_select_n, 3) == 1'b0 ||
      $past(chip_select_n, 4) == 1'b0) else $error("read without chip select");
  AST_EN_POLARITY:
    assert property (s_first_take |-> $past(receive_output_enable, 2) ==
      $past(cascade_fifo_select, 2)) else $error("enable polarity wrong");
  AST_OE_ON:
    assert property (s_first_take ##0 !ctrl_q[`CTRL_OUT_DIS] |-> ##[1:2] receive_data_bus_oe)
      else $error("pins not driven after selection");
  AST_OE_OFF:
    assert property (s_en_off [*6] |-> !receive_data_bus_oe) else $error("pins still driven");
  AST_HOLD:
    assert property (!take |=> $stable(outs)) else $error("outputs moved without a character");
  AST_W8_CMD:
    assert property (take && dec && w8 && char_is_cmd |=> command_data_flag &&
      {receive_data_bus[9:8], receive_command_bus} == bits_q[3:0] &&
      $stable(receive_data_bus[7:0])) else $error("8-bit command wrong");
  AST_W10_DATA:
    assert property (take && dec && !w8 && !char_is_cmd |=> !command_data_flag &&
      receive_data_bus == bits_q[9:0] && $stable(receive_command_bus))
      else $error("10-bit data wrong");
  AST_BYPASS:
    assert property (take && !dec |=> receive_data_bus == bits_q[9:0] &&
      receive_command_bus == ($past(w8) ? 2'b00 : bits_q[11:10]))
      else $error("raw character wrong");
  AST_FIFO_BYPASS:
    assert property (!fifo |-> char_ready == clk_en) else $error("bypass ready wrong");
endmodule

bind rx_parallel_output_port rx_port_chk rx_port_chk_inst (.pclk, .presetn, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .receive_output_enable, .chip_select_n,
  .cascade_fifo_select, .char_valid, .char_ready, .char_is_cmd, .char_bits,
  .receive_data_bus, .receive_data_bus_oe, .receive_command_bus, .receive_command_bus_oe,
  .command_data_flag, .command_data_flag_oe);

// >>> test/host_model.sv
// host-side model that selects the port for a burst of reads
`timescale 1ns/1ns
module host_model (
  input  wire logic pclk,
  input  wire logic cascade_fifo_select,
  output logic      chip_select_n,
  output wire       receive_output_enable
);
  logic en_act = 1'b0;
  initial chip_select_n = 1'b1;
  // pin level follows the polarity picked by the cascade select
  assign receive_output_enable = en_act ? cascade_fifo_select : !cascade_fifo_select;
  // chip select leads by a cycle so the enable lands in the cycle after it
  task automatic read_burst(input int len);
    @(posedge pclk);
    chip_select_n <= 1'b0;
    @(posedge pclk);
    en_act <= 1'b1;
    @(posedge pclk);
    chip_select_n <= 1'b1;
    repeat (len) @(posedge pclk);
    en_act <= 1'b0;
  endtask
endmodule

// >>> test/rx_parallel_output_port_bench.sv
// self-checking bench for the receive parallel output port
`timescale 1ns/1ns
`include "rx_port_map.vh"
module rx_parallel_output_port_bench;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pol, saw_oe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  logic        char_valid, char_is_cmd, took, err;
  logic [11:0] char_bits;
  logic [12:0] model_q;
  logic [3:0]  mode;
  logic [3:0]  modes [4] = '{4'h3, 4'h2, 4'h1, 4'h0};
  logic [12:0] exp_q [$];
  wire  [31:0] prdata;
  wire         pready, pslverr, char_ready, ce_n, en_pin, dat_oe, cmd_oe, flg_oe, flag;
  wire  [9:0]  dbus;
  wire  [1:0]  cbus;
  int          mismatches, n_tests, ndat, ncmd;

  rx_parallel_output_port rx_parallel_output_port_inst (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receive_output_enable(en_pin), .chip_select_n(ce_n), .cascade_fifo_select(pol),
    .char_valid(char_valid), .char_ready(char_ready), .char_is_cmd(char_is_cmd),
    .char_bits(char_bits), .receive_data_bus(dbus), .receive_data_bus_oe(dat_oe),
    .receive_command_bus(cbus), .receive_command_bus_oe(cmd_oe),
    .command_data_flag(flag), .command_data_flag_oe(flg_oe));
  host_model host_model_inst (.pclk(pclk), .cascade_fifo_select(pol),
    .chip_select_n(ce_n), .receive_output_enable(en_pin));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // fields left alone by a character keep the previous value
  function automatic logic [12:0] next_out(input logic [3:0] m, input logic c,
                                           input logic [11:0] b, input logic [12:0] p);
    if (!m[1]) return {b[9:0], m[0] ? 2'b00 : b[11:10], 1'b0};
    if (m[0]) return c ? {b[3:2], p[10:3], b[1:0], 1'b1} : {p[12:11], b[7:0], p[2:1], 1'b0};
    return c ? {p[12:3], b[1:0], 1'b1} : {b[9:0], p[2:1], 1'b0};
  endfunction
  task automatic stream(input int k);
    int n;
    for (int i = 0; i < k; i++) begin
      char_bits <= 12'($urandom);
      char_is_cmd <= 1'($urandom);
      char_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (char_ready !== 1'b1 && n < 200);
      check({31'h0, char_ready}, 32'h1);
      model_q = next_out(mode, char_is_cmd, char_bits, model_q);
      exp_q.push_back(model_q);
      if (char_is_cmd) ncmd++;
      else ndat++;
    end
    char_valid <= 1'b0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // result watcher and watchdog
  // ----------------------------------------
  always @(posedge pclk) begin
    if (took) begin
      if (exp_q.size() == 0) check(32'h0, 32'h1);
      else check({dbus, cbus, flag}, exp_q.pop_front());
    end
    took = char_valid && char_ready && presetn;
    if (dat_oe === 1'b1) saw_oe = 1'b1;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_sim();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, char_valid, char_is_cmd, pol, took, saw_oe} = '0;
    {paddr, pwdata, char_bits, model_q} = '0;
    clk_en = 1'b1;
    mode = `CTRL_RESET;
    void'($urandom(15849));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `ADDR_CTRL, 0);
    check(rd, 32'h7);
    apb(1, 8'h40, 32'h0);
    check(32'(err), 32'h1);
    apb(1, `ADDR_CTRL, 32'hffffffff);
    apb(0, `ADDR_CTRL, 0);
    check(rd, 32'hf);
    apb(0, 8'h14, 0);
    check(32'(err), 32'h1);
    $display("test registers done");
    // setup phase frozen by the clock enable: the read must still be right
    clk_en <= 1'b0;
    fork
      apb(0, `ADDR_CTRL, 0);
      begin
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    check(rd, 32'hf);
    $display("test clock enable done");
    // fifo bypassed: characters flow without selection
    foreach (modes[i]) begin
      mode = modes[i];
      apb(1, `ADDR_CTRL, {28'h0, mode});
      stream(10);
      $display("test mode %h done", mode);
    end
    for (int p = 0; p < 3; p++) begin
      pol <= p[0];
      mode = (p == 0) ? 4'h7 : (p == 1) ? 4'h6 : 4'hf;
      apb(1, `ADDR_CTRL, {28'h0, mode});
      apb(1, `ADDR_COUNT, 0);
      {ndat, ncmd, saw_oe} = '0;
      fork
        host_model_inst.read_burst(24);
        stream(12);
      join
      check(32'(saw_oe), 32'(!mode[3]));
      repeat (8) @(posedge pclk);
      check({dat_oe, cmd_oe, flg_oe}, 32'h0);
      apb(0, `ADDR_COUNT, 0);
      check(rd, {ncmd[15:0], ndat[15:0]});
      apb(0, `ADDR_STATUS, 0);
      check(32'(rd[`STAT_POL_HIGH]), 32'(pol));
      $display("test polarity %0d done", p);
    end
    repeat (4) @(posedge pclk);
    check(exp_q.size(), 0);
    end_sim();
  end
endmodule
